// >>> hw/isec_ctrl.sv
// Purpose: mode detect, burst scheduling and gate drive control
// Assumes: reset comes from the supply monitors, all inputs asynchronous
// Notes: analog parts (rectifier, modulator, thresholds) are outside
//
// Function
// - two-wire start is enable high, powers device
// - two-wire burst of fixed 3.3 us at peak
// - two-wire bursts repeat hysteretically, variable period
// - gate high after upper rail charged, while enabled
// - two-wire enable fall: gate low first, then transfer stops
// - seven current limits, out of range gives lowest
// - level sampled once at power-up, then held
// - primary undervoltage stops all transfer
// - primary loss drives gate low, timeout backs it
// - upper or middle rail low forces gate low
// - monitors use separate rising and falling levels
// - secondary monitors ignore switching dips
// - mode detected at power-up, held until reset
// - enable high before primary good means two-wire
// - primary good starts transfer, gate may assert
// - over-temperature stops transfer, forces gate low
// - standard enable: gate follows enable
// - one-shot: one pulse per enable rising edge
// - upper rail down: gate low, keep-off on
// - primary down, rail up: disable after timeout
// - three-wire fixed period, seven duty levels
// - three-wire transfer independent of enable
`timescale 1ns/1ps
module isec_ctrl #(
    parameter int PULSE_CYC = isec_pkg::PULSE_CYC_DEF,
    parameter int TIMEOUT_CYC = isec_pkg::TIMEOUT_CYC_DEF,
    parameter int UNIT_CYC = isec_pkg::UNIT_CYC_DEF,
    parameter int SEC_FILT_CYC = isec_pkg::SEC_FILT_CYC_DEF
) (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    // enable pin and straps
    input wire logic I_EN,
    input wire logic [2:0] I_XFER_SEL,
    input wire logic I_ONE_SHOT_OPT,
    // primary supply comparators
    input wire logic I_PRI_RISE_OK,
    input wire logic I_PRI_FALL_OK,
    input wire logic I_PRI_AT_PEAK,
    // secondary rail comparators
    input wire logic I_HI_RISE_OK,
    input wire logic I_HI_FALL_OK,
    input wire logic I_MID_RISE_OK,
    input wire logic I_MID_FALL_OK,
    // thermal sensor
    input wire logic I_OVER_TEMP,
    // gate driver
    output logic O_GATE_DRIVE,
    output logic O_DRV_ENABLE,
    output logic O_KEEP_OFF,
    // power transfer and status
    output logic O_BURST,
    output logic O_MODE_VALID,
    output logic O_MODE_TWO_WIRE,
    output logic [2:0] O_XFER_LEVEL
);
    localparam int BW = 16; // burst counter width
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int PERIOD_CYC = isec_pkg::DUTY_STEPS * UNIT_CYC;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PULSE_CYC < 1 || TIMEOUT_CYC < 1 || UNIT_CYC < 1 ||
        PERIOD_CYC >= (1 << BW)) begin : g_chk
        $error("isec_ctrl: count parameter out of range");
    end

    // on-time of a three-wire burst for a level code
    function automatic logic [BW-1:0] on_cyc(input logic [2:0] lvl);
        on_cyc = BW'((isec_pkg::DUTY_BASE + isec_pkg::DUTY_STEP
                      * int'(lvl)) * UNIT_CYC);
    endfunction

    // ------------------------------------------------------------
    // supply monitors
    // ------------------------------------------------------------
    isec_uv_if pri_uv ();
    isec_uv_if hi_uv ();
    isec_uv_if mid_uv ();

    assign pri_uv.rise_raw = I_PRI_RISE_OK;
    assign pri_uv.fall_raw = I_PRI_FALL_OK;
    assign hi_uv.rise_raw = I_HI_RISE_OK;
    assign hi_uv.fall_raw = I_HI_FALL_OK;
    assign mid_uv.rise_raw = I_MID_RISE_OK;
    assign mid_uv.fall_raw = I_MID_FALL_OK;

    // primary acts at once; secondary blanks switching dips
    isec_uv_filter #(.FILT_CYC(isec_pkg::PRI_FILT_CYC_DEF)) u_pri (
        .clk(I_MCLK),
        .rst_n(I_RESET_N),
        .uv(pri_uv)
    );
    isec_uv_filter #(.FILT_CYC(SEC_FILT_CYC)) u_hi (
        .clk(I_MCLK),
        .rst_n(I_RESET_N),
        .uv(hi_uv)
    );
    isec_uv_filter #(.FILT_CYC(SEC_FILT_CYC)) u_mid (
        .clk(I_MCLK),
        .rst_n(I_RESET_N),
        .uv(mid_uv)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] sy1_reg; // first stage, read only by sy2_reg
    logic [6:0] sy2_reg; // {oneshot, sel[2:0], temp, peak, en}
    logic en_d_reg;      // delayed enable for edges

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            sy1_reg <= 7'h00;
            sy2_reg <= 7'h00;
            en_d_reg <= 1'b0;
        end else begin
            sy1_reg <= {I_ONE_SHOT_OPT, I_XFER_SEL, I_OVER_TEMP,
                        I_PRI_AT_PEAK, I_EN};
            sy2_reg <= sy1_reg;
            en_d_reg <= sy2_reg[0];
        end
    end

    logic en_s, peak_s, ot_s, oneshot_s;
    logic [2:0] sel_s;
    logic en_rise;
    assign en_s = sy2_reg[0];
    assign peak_s = sy2_reg[1];
    assign ot_s = sy2_reg[2];
    assign sel_s = sy2_reg[5:3];
    assign oneshot_s = sy2_reg[6];
    assign en_rise = en_s && !en_d_reg;

    // ------------------------------------------------------------
    // mode and level latch
    // ------------------------------------------------------------
    isec_pkg::isec_mode_t mode_reg, mode_next;
    logic [2:0] lvl_reg, lvl_next;
    logic oneshot_reg, oneshot_next;
    logic mvalid_reg, mvalid_next; // mode detected, for the pin
    logic m2_reg, m2_next;         // two-wire flag, for the pin

    // sampled once when primary first becomes good, held until reset
    always_comb begin
        mode_next = mode_reg;
        lvl_next = lvl_reg;
        oneshot_next = oneshot_reg;
        if (mode_reg == isec_pkg::ISEC_MODE_NONE && pri_uv.good) begin
            // enable already high means the pin powers the device
            mode_next = en_s ? isec_pkg::ISEC_MODE_TWO
                             : isec_pkg::ISEC_MODE_THREE;
            // out-of-range resistor falls back to the lowest level
            lvl_next = (sel_s == isec_pkg::LVL_INVALID) ?
                       isec_pkg::LVL_LOWEST : sel_s;
            oneshot_next = oneshot_s;
        end
        // status pins come straight from flops, no decode glitches
        mvalid_next = (mode_next != isec_pkg::ISEC_MODE_NONE);
        m2_next = (mode_next == isec_pkg::ISEC_MODE_TWO);
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            mode_reg <= isec_pkg::ISEC_MODE_NONE;
            lvl_reg <= isec_pkg::LVL_LOWEST;
            oneshot_reg <= 1'b0;
            mvalid_reg <= 1'b0;
            m2_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            lvl_reg <= lvl_next;
            oneshot_reg <= oneshot_next;
            mvalid_reg <= mvalid_next;
            m2_reg <= m2_next;
        end
    end

    logic two_w, three_w, os_mode;
    assign two_w = (mode_reg == isec_pkg::ISEC_MODE_TWO);
    assign three_w = (mode_reg == isec_pkg::ISEC_MODE_THREE);
    assign os_mode = three_w && oneshot_reg;

    // ------------------------------------------------------------
    // burst scheduler
    // ------------------------------------------------------------
    // two-wire transfer lags enable by one cycle so the gate-off
    // command leaves before the primary starts to collapse
    logic xfer_ok;
    assign xfer_ok = pri_uv.good && !ot_s &&
                     (three_w || (two_w && en_d_reg));

    isec_pkg::isec_burst_t bst_reg, bst_next;
    logic [BW-1:0] bcnt_reg, bcnt_next;
    logic burst_reg, burst_next;

    always_comb begin
        bst_next = bst_reg;
        bcnt_next = bcnt_reg;
        case (bst_reg)
            isec_pkg::ISEC_B_IDLE: begin
                if (xfer_ok && three_w) begin
                    bst_next = isec_pkg::ISEC_B_ON;
                    bcnt_next = on_cyc(lvl_reg) - BW'(1);
                end else if (xfer_ok && peak_s) begin
                    // period varies with how fast the pin recharges
                    bst_next = isec_pkg::ISEC_B_ON;
                    bcnt_next = BW'(isec_pkg::BURST_2W_CYC - 1);
                end
            end
            isec_pkg::ISEC_B_ON: begin
                if (!xfer_ok) begin
                    bst_next = isec_pkg::ISEC_B_IDLE;
                end else if (bcnt_reg != '0) begin
                    bcnt_next = bcnt_reg - BW'(1);
                end else if (two_w) begin
                    bst_next = isec_pkg::ISEC_B_IDLE;
                end else begin
                    bst_next = isec_pkg::ISEC_B_OFF;
                    bcnt_next = BW'(PERIOD_CYC) - on_cyc(lvl_reg)
                                - BW'(1);
                end
            end
            isec_pkg::ISEC_B_OFF: begin
                if (!xfer_ok) begin
                    bst_next = isec_pkg::ISEC_B_IDLE;
                end else if (bcnt_reg != '0) begin
                    bcnt_next = bcnt_reg - BW'(1);
                end else begin
                    bst_next = isec_pkg::ISEC_B_ON;
                    bcnt_next = on_cyc(lvl_reg) - BW'(1);
                end
            end
            default: begin
                bst_next = isec_pkg::ISEC_B_IDLE;
            end
        endcase
        burst_next = (bst_next == isec_pkg::ISEC_B_ON);
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            bst_reg <= isec_pkg::ISEC_B_IDLE;
            bcnt_reg <= '0;
            burst_reg <= 1'b0;
        end else begin
            bst_reg <= bst_next;
            bcnt_reg <= bcnt_next;
            burst_reg <= burst_next;
        end
    end

    // ------------------------------------------------------------
    // gate drive and keep-off
    // ------------------------------------------------------------
    logic drive_ok;
    assign drive_ok = (mode_reg != isec_pkg::ISEC_MODE_NONE) &&
                      pri_uv.good && hi_uv.good && mid_uv.good &&
                      !ot_s;

    logic gate_reg, gate_next;
    logic [PW-1:0] pcnt_reg, pcnt_next;   // one-shot width count
    logic [TW-1:0] tcnt_reg, tcnt_next;   // primary loss count
    logic texp_reg, texp_next;            // primary loss timed out
    logic koff_reg, koff_next;
    logic drv_en_reg, drv_en_next;

    always_comb begin
        gate_next = gate_reg;
        pcnt_next = pcnt_reg;
        if (!drive_ok) begin
            gate_next = 1'b0;
            pcnt_next = '0;
        end else if (os_mode) begin
            // edge only after the pin went low, so one pulse per rise
            if (en_rise) begin
                gate_next = 1'b1;
                pcnt_next = PW'(PULSE_CYC - 1);
            end else if (gate_reg) begin
                if (pcnt_reg == '0) begin
                    gate_next = 1'b0;
                end else begin
                    pcnt_next = pcnt_reg - PW'(1);
                end
            end
        end else begin
            gate_next = en_s;
        end
        // secondary timeout covers a primary too weak to signal
        tcnt_next = tcnt_reg;
        texp_next = texp_reg;
        if (pri_uv.good) begin
            tcnt_next = '0;
            texp_next = 1'b0;
        end else if (!texp_reg) begin
            if (tcnt_reg == TW'(TIMEOUT_CYC - 1)) begin
                texp_next = 1'b1;
            end else begin
                tcnt_next = tcnt_reg + TW'(1);
            end
        end
        koff_next = !hi_uv.good || texp_next;
        drv_en_next = !koff_next;
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            gate_reg <= 1'b0;
            pcnt_reg <= '0;
            tcnt_reg <= '0;
            texp_reg <= 1'b0;
            koff_reg <= 1'b1;
            drv_en_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            pcnt_reg <= pcnt_next;
            tcnt_reg <= tcnt_next;
            texp_reg <= texp_next;
            koff_reg <= koff_next;
            drv_en_reg <= drv_en_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_GATE_DRIVE = gate_reg;
    assign O_DRV_ENABLE = drv_en_reg;
    assign O_KEEP_OFF = koff_reg;
    assign O_BURST = burst_reg;
    assign O_MODE_VALID = mvalid_reg;
    assign O_MODE_TWO_WIRE = m2_reg;
    assign O_XFER_LEVEL = lvl_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    property p_burst_len;
        $rose(burst_reg) && two_w |-> bcnt_reg ==
            BW'(isec_pkg::BURST_2W_CYC - 1);
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("two-wire burst started with wrong length");

    property p_gate_follow;
        drive_ok && !os_mode && en_s |=> gate_reg;
    endproperty
    a_gate_follow: assert property (p_gate_follow)
        else $error("gate did not follow enable");

    property p_rail_low;
        !(hi_uv.good && mid_uv.good) |=> !gate_reg;
    endproperty
    a_rail_low: assert property (p_rail_low)
        else $error("gate high with a secondary rail low");

    property p_pri_stop;
        !pri_uv.good |=> !burst_reg;
    endproperty
    a_pri_stop: assert property (p_pri_stop)
        else $error("transfer while primary undervoltage");

    property p_hot;
        ot_s |=> !burst_reg && !gate_reg;
    endproperty
    a_hot: assert property (p_hot)
        else $error("transfer or gate during over-temperature");

    property p_en_fall;
        two_w && $fell(en_s) |=> !gate_reg ##1 !burst_reg;
    endproperty
    a_en_fall: assert property (p_en_fall)
        else $error("gate or transfer not stopped on enable fall");

    property p_mode_hold;
        O_MODE_VALID |=> $stable(mode_reg) && $stable(lvl_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode or level changed after detection");

    property p_one_shot;
        os_mode && $rose(gate_reg) |-> $past(en_rise);
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("one-shot pulse without enable rising edge");

    property p_timeout;
        texp_reg |-> koff_reg && !drv_en_reg && !gate_reg;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("driver not disabled after primary timeout");

    c_two_wire: cover property ($rose(burst_reg) && two_w);
    c_three_wire: cover property (three_w && $rose(gate_reg));
    c_one_shot: cover property (os_mode && $fell(gate_reg) && en_s);
    c_timeout: cover property ($rose(texp_reg) && hi_uv.good);
endmodule

// >>> hw/isec_uv_filter.sv
// Purpose: synchronise, hysteresis and dip blanking of one supply monitor
// Assumes: comparator outputs arrive asynchronously
// Notes: a failure must persist FILT_CYC cycles before good drops
`timescale 1ns/1ps
module isec_uv_filter #(
    parameter int FILT_CYC = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // monitored supply
    isec_uv_if.flt uv
);
    localparam int CW = $clog2(FILT_CYC + 1);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (FILT_CYC < 1) begin : g_chk
        $error("isec_uv_filter: FILT_CYC must be at least one");
    end

    logic [1:0] s1_reg; // first sync stage, read only by s2
    logic [1:0] s2_reg; // synchronised {rise, fall}
    logic good_reg, good_next;
    logic [CW-1:0] cnt_reg, cnt_next; // failure persistence count

    // two-stage synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
        end else begin
            s1_reg <= {uv.rise_raw, uv.fall_raw};
            s2_reg <= s1_reg;
        end
    end

    // hysteresis: good only above rising, failed only below falling
    always_comb begin
        good_next = good_reg;
        cnt_next = cnt_reg;
        if (!good_reg) begin
            cnt_next = '0;
            if (s2_reg[1]) begin
                good_next = 1'b1;
            end
        end else if (!s2_reg[0]) begin
            // switching dips are short; blank them out
            if (cnt_reg == CW'(FILT_CYC - 1)) begin
                good_next = 1'b0;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end else begin
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            good_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            good_reg <= good_next;
            cnt_reg <= cnt_next;
        end
    end

    assign uv.good = good_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_uv_no_rise;
        @(posedge clk) disable iff (!rst_n)
        !good_reg && !s2_reg[1] |=> !good_reg;
    endproperty
    a_uv_no_rise: assert property (p_uv_no_rise)
        else $error("supply became good without rising level");

    property p_uv_dip;
        @(posedge clk) disable iff (!rst_n)
        (FILT_CYC > 1) && good_reg && s2_reg[0] ##1 !s2_reg[0]
        |=> good_reg;
    endproperty
    a_uv_dip: assert property (p_uv_dip)
        else $error("single cycle dip dropped the supply status");
endmodule

// >>> shared/isec_pkg.sv
// Purpose: shared constants and types of the isolated switch enable control
// Assumes: core clock of 25 MHz, analog comparators outside this logic
// Notes: the level code selects both the enable current limit (two-wire)
//        and the burst duty cycle (three-wire)
package isec_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;      // 25 MHz core clock
    localparam int BURST_2W_NS = 3300;      // two-wire burst length, ns
    // least time, so round up to whole cycles
    localparam int BURST_2W_CYC = (BURST_2W_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // transfer level code
    // ------------------------------------------------------------
    localparam int LVL_W = 3;                 // width of the level code
    localparam logic [2:0] LVL_LOWEST = 3'h0; // 1.9 mA / 13.3 %
    localparam logic [2:0] LVL_INVALID = 3'h7; // resistor out of range
    localparam int DUTY_STEPS = 15;           // period in duty units
    localparam int DUTY_BASE = 2;             // on units at level 0
    localparam int DUTY_STEP = 2;             // on units added per level

    // ------------------------------------------------------------
    // defaults of the tunable counts
    // ------------------------------------------------------------
    localparam int PULSE_CYC_DEF = 250;       // one-shot width, 10 us
    localparam int TIMEOUT_CYC_DEF = 12500;   // primary loss timeout
    localparam int UNIT_CYC_DEF = 10;         // cycles per duty unit
    localparam int SEC_FILT_CYC_DEF = 8;      // secondary dip blanking
    localparam int PRI_FILT_CYC_DEF = 1;      // primary acts at once

    // ------------------------------------------------------------
    // operating mode and burst states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ISEC_MODE_NONE  = 2'b00,
        ISEC_MODE_TWO   = 2'b01,
        ISEC_MODE_THREE = 2'b10
    } isec_mode_t;

    typedef enum logic [1:0] {
        ISEC_B_IDLE = 2'b00,
        ISEC_B_ON   = 2'b01,
        ISEC_B_OFF  = 2'b10
    } isec_burst_t;

endpackage

// >>> shared/isec_uv_if.sv
// Purpose: carries one supply monitor between control and filter
// Assumes: raw comparator levels are asynchronous to the core clock
// Notes: good is a registered, filtered supply status
`timescale 1ns/1ps
interface isec_uv_if;
    logic rise_raw; // supply above its rising level
    logic fall_raw; // supply above its falling level
    logic good;     // filtered supply status

    // filter side
    modport flt (
        input rise_raw,
        input fall_raw,
        output good
    );
    // control side
    modport ctl (
        output rise_raw,
        output fall_raw,
        input good
    );
endinterface

// >>> verif/isec_app_model.sv
// Purpose: application side driving the enable pin and primary supply
// Assumes: two-wire primary charges from enable, three-wire is separate
// Notes: bench inputs pass at once; the supply lag steps on the rising
//        edge, so it never races the bench's falling-edge changes
`timescale 1ns/1ps
module isec_app_model (
    // bench control
    input wire logic i_clk,
    input wire logic i_two_wire,
    input wire logic i_pwr,
    input wire logic i_en_cmd,
    // device pins
    output logic o_en,
    output logic o_pri_ok,
    output logic o_peak
);
    logic [2:0] dly_reg = 3'h0; // supply charge-up lag
    // ------------------------------------------------------------
    // supply follows its source a few cycles late
    // ------------------------------------------------------------
    // non-blocking on the rising edge: the device samples the old level
    always @(posedge i_clk) begin
        dly_reg <= {dly_reg[1:0], i_two_wire ? i_en_cmd : i_pwr};
    end
    // enable leads in two-wire; steep edges, so no slow ramp toggling
    assign o_en = i_two_wire ? i_en_cmd
                             : i_en_cmd & dly_reg[2];
    assign o_pri_ok = i_two_wire ? dly_reg[2] : i_pwr;
    assign o_peak = i_two_wire & o_pri_ok;
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench of the switch enable control
// Assumes: short counts so every path is reached quickly
// Notes: rising and falling comparator levels of a rail move together, except the upper rail, whose rising level is also gated by hr
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, tw, pwr, enc, en, pri, pk, os, hot, hi, mid, hr;
    logic gate, drv, koff, bst, mv, m2;
    logic [2:0] sel, lvl;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    isec_app_model i_app (.i_clk(clk), .i_two_wire(tw), .i_pwr(pwr),
        .i_en_cmd(enc), .o_en(en), .o_pri_ok(pri), .o_peak(pk));
    isec_ctrl #(.PULSE_CYC(5), .TIMEOUT_CYC(20), .UNIT_CYC(1),
        .SEC_FILT_CYC(3)) i_dut (.I_MCLK(clk), .I_RESET_N(rst_n),
        .I_EN(en), .I_XFER_SEL(sel), .I_ONE_SHOT_OPT(os),
        .I_PRI_RISE_OK(pri), .I_PRI_FALL_OK(pri), .I_PRI_AT_PEAK(pk),
        .I_HI_RISE_OK(hi & hr), .I_HI_FALL_OK(hi), .I_MID_RISE_OK(mid),
        .I_MID_FALL_OK(mid), .I_OVER_TEMP(hot), .O_GATE_DRIVE(gate),
        .O_DRV_ENABLE(drv), .O_KEEP_OFF(koff), .O_BURST(bst),
        .O_MODE_VALID(mv), .O_MODE_TWO_WIRE(m2), .O_XFER_LEVEL(lvl));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // count cycles of gate (g set) or burst high in a window
    task automatic cnt(input bit g, input int len);
        n = 0;
        repeat (len) begin
            @(negedge clk);
            n += int'((g ? gate : bst) === 1'b1);
        end
    endtask
    // reset for 16 cycles, then power up in the chosen mode
    task automatic start(input bit t, input logic [2:0] s);
        rst_n = 0;
        pwr = 0;
        enc = 0;
        tw = t;
        sel = s;
        cyc(16);
        rst_n = 1;
        pwr = 1;
        enc = t;
        cyc(12);
    endtask
    task automatic t_levels();
        for (int s = 0; s < 8; s++) begin
            start(1'b0, 3'(s));
            chk("valid", 8'h1, 8'(mv));
            chk("two_wire", 8'h0, 8'(m2));
            chk("level", 8'((s == 7) ? 0 : s), 8'(lvl));
            cnt(1'b0, 30);
            chk("on_cycles", 8'(4 * ((s == 7) ? 1 : s + 1)), 8'(n));
        end
        $display("t_levels done");
    endtask
    task automatic t_std();
        start(1'b0, 3'h0);
        enc = 1;
        cyc(5);
        chk("gate_on", 8'h1, 8'(gate));
        mid = 0;
        cyc(2);
        mid = 1;
        cyc(4);
        chk("gate_dip", 8'h1, 8'(gate));
        mid = 0;
        cyc(8);
        chk("gate_mid", 8'h0, 8'(gate));
        mid = 1;
        hot = 1;
        cyc(4);
        chk("gate_hot", 8'h0, 8'(gate));
        cnt(1'b0, 20);
        chk("burst_hot", 8'h0, 8'(n));
        hot = 0;
        cyc(10);
        chk("gate_back", 8'h1, 8'(gate));
        enc = 0;
        cyc(5);
        chk("gate_off", 8'h0, 8'(gate));
        hi = 0;
        cyc(8);
        chk("keep_hi", 8'h1, 8'(koff));
        chk("drv_hi", 8'h0, 8'(drv));
        hr = 0;
        hi = 1;
        enc = 1;
        cyc(8);
        chk("keep_hyst", 8'h1, 8'(koff));
        hr = 1;
        cyc(8);
        pwr = 0;
        cyc(5);
        chk("gate_pri", 8'h0, 8'(gate));
        chk("burst_pri", 8'h0, 8'(bst));
        chk("keep_early", 8'h0, 8'(koff));
        cyc(25);
        chk("keep_late", 8'h1, 8'(koff));
        chk("drv_late", 8'h0, 8'(drv));
        $display("t_std done");
    endtask
    task automatic t_two();
        start(1'b1, 3'h3);
        chk("two_wire", 8'h1, 8'(m2));
        chk("level", 8'h3, 8'(lvl));
        sel = 3'h5;
        cyc(2);
        chk("level_held", 8'h3, 8'(lvl));
        for (int k = 0; k < 100 && bst !== 1'b0; k++)
            cyc(1);
        for (int k = 0; k < 100 && bst !== 1'b1; k++)
            cyc(1);
        for (n = 0; n < 200 && bst === 1'b1; n++)
            cyc(1);
        chk("burst_len", 8'd83, 8'(n));
        chk("gate_up", 8'h1, 8'(gate));
        enc = 0;
        cyc(5);
        chk("gate_fall", 8'h0, 8'(gate));
        cnt(1'b0, 8);
        chk("burst_stop", 8'h0, 8'(n));
        $display("t_two done");
    endtask
    task automatic t_one();
        os = 1;
        start(1'b0, 3'h0);
        repeat (2) begin
            enc = 1;
            cnt(1'b1, 20);
            chk("pulse", 8'h5, 8'(n));
            enc = 0;
            cyc(4);
        end
        $display("t_one done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            $display("BAD cycles exp below %0d got %0d", 5000, cycles);
            failures++;
            stop_test();
        end
    end
    initial begin
        rst_n = 0;
        tw = 0;
        pwr = 0;
        enc = 0;
        os = 0;
        hot = 0;
        hi = 1;
        mid = 1;
        hr = 1;
        sel = 3'h0;
        t_levels();
        t_std();
        t_two();
        t_one();
        stop_test();
    end
endmodule
